// *** seismic_node_ctrl.sv ***
// node controller: filter serial port, sync re-timing, record start, addressing
//
// Overview of operation
// RL1: record start marks first collected record sample
// RL2: skip 100 settling samples, then mark
// RL3: logic runs on 12 MHz clock
// RL4: reset comes only from button input
// RL5: drive active-low reset after power-on
// RL6: master filter port with active-low select
// RL7: sample ready input is active low
// RL8: accept host commands, return collected data
// RL9: direct mode passes network sync unaltered
// RL10: hardware mode detects sync, re-times output
// RL11: software mode pulses sync on command
// RL12: sync alignment within plus/minus 240 ns
// RL13: every node holds a unique address
// RL14: address targets commands and tags data
// RL15: pass-through enabled after own address received
// RL16: no arbitration or high-impedance nack reliance
// RL17: filter sync and mark are OR-combined
// RL18: programmable re-timing delay in clock cycles
// RL19: drive enable only while transmitting data
`timescale 1ns/1ps
module seismic_node_ctrl
  import node_ctrl_pkg::*;
#(
  parameter int SETTLE = SETTLE_SAMPLES,
  parameter int SBITS  = SAMPLE_BITS
)(
  // clock and button reset (12 MHz)
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  output logic                       power_on_reset_n_out,
  output logic                       filter_reset_drive_out,
  // sync and record controls
  input  wire logic [1:0]            sync_mode_in,
  input  wire logic [DELAY_BITS-1:0] sync_delay_in,
  input  wire logic                  sync_network_in,
  input  wire logic                  sync_button_in,
  input  wire logic                  record_button_in,
  output logic                       node_sync_out,
  output logic                       filter_sync_out,
  output logic                       record_start_mark,
  output logic                       filter_record_out,
  // host command port
  input  wire logic                  cmd_valid_in,
  output logic                       cmd_ready_out,
  input  wire logic [ADDR_BITS-1:0]  cmd_addr_in,
  input  wire logic [CMD_BITS-1:0]   cmd_code_in,
  input  wire logic [31:0]           cmd_data_in,
  output logic                       cfg_rdata_valid_out,
  output logic [31:0]                cfg_rdata_out,
  // collected data toward host
  output logic                       data_valid_out,
  input  wire logic                  data_ready_in,
  output logic [ADDR_BITS-1:0]       data_src_addr_out,
  output logic [SBITS-1:0]           data_sample_out,
  output logic                       data_first_out,
  // address assignment
  input  wire logic                  addr_assign_in,
  input  wire logic [ADDR_BITS-1:0]  addr_value_in,
  output logic [ADDR_BITS-1:0]       node_addr_out,
  output logic                       chain_pass_enable,
  // telemetry data line driver
  input  wire logic                  link_tx_active_in,
  output logic                       link_data_drive_en,
  // filter serial port
  output logic                       filter_sck_out,
  output logic                       filter_mosi_out,
  output logic                       filter_select_n,
  input  wire logic                  filter_miso_in,
  input  wire logic                  sample_ready_n
);
  import node_ctrl_pkg::*;

  // -------------------------------------------------------------
  // command codes and local types
  // -------------------------------------------------------------
  localparam logic [7:0] CMD_CFG_WRITE = 8'h01;
  localparam logic [7:0] CMD_CFG_READ  = 8'h02;
  localparam logic [7:0] CMD_SYNC      = 8'h03;
  localparam logic [7:0] CMD_RUN       = 8'h04;
  localparam logic [7:0] CMD_STOP      = 8'h05;
  localparam logic [7:0] CMD_FILT_RST  = 8'h06;
  typedef enum logic [1:0] {ACQ_IDLE, ACQ_SETTLE, ACQ_RECORD} acq_t;

  // -------------------------------------------------------------
  // power-on reset output
  // -------------------------------------------------------------
  logic [15:0] por_count;
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)  // RL4
    begin
      por_count            <= 16'h0000;
      power_on_reset_n_out <= 1'b0;
    end
    else if (por_count != 16'(POR_CYCLES))  // RL3
      por_count <= por_count + 16'h0001;
    else
      power_on_reset_n_out <= 1'b1;  // RL5
  end

  // -------------------------------------------------------------
  // pin synchronisers: three stages, change once last two agree
  // -------------------------------------------------------------
  logic [2:0] net_sync_q;
  logic [2:0] drdy_q;
  logic       net_level;
  logic       net_level_d;
  logic       drdy_level;
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      net_sync_q  <= 3'h0;
      drdy_q      <= 3'h7;
      net_level   <= 1'b0;
      net_level_d <= 1'b0;
      drdy_level  <= 1'b1;
    end
    else
    begin
      net_sync_q  <= {net_sync_q[1:0], sync_network_in};
      drdy_q      <= {drdy_q[1:0], sample_ready_n};
      if (net_sync_q[1] == net_sync_q[2])
        net_level <= net_sync_q[2];
      if (drdy_q[1] == drdy_q[2])
        drdy_level <= drdy_q[2];
      net_level_d <= net_level;
    end
  end

  // -------------------------------------------------------------
  // command decode
  // -------------------------------------------------------------
  logic       spi_busy;
  logic       spi_done;
  logic       spi_start;
  logic [31:0] spi_tx;
  logic [31:0] spi_rx;
  spi_op_t    op;
  logic       cmd_take;
  logic       for_me;
  assign for_me   = (cmd_addr_in == node_addr_out);  // RL14
  assign cmd_ready_out = ~spi_busy & (op == OP_NONE);
  assign cmd_take = cmd_valid_in & cmd_ready_out & for_me;  // RL8

  // -------------------------------------------------------------
  // sync generation
  // -------------------------------------------------------------
  logic [DELAY_BITS-1:0] delay_count;
  logic                  delay_run;
  logic [7:0]            pulse_count;
  logic                  trigger;
  always_comb
  begin
    trigger = 1'b0;
    if (sync_mode_in == SYNC_MODE_HARDWARE)
      trigger = net_level & ~net_level_d;  // RL10
    else if (sync_mode_in == SYNC_MODE_SOFTWARE)
      trigger = cmd_take & (cmd_code_in == CMD_SYNC);  // RL11
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      delay_count   <= '0;
      delay_run     <= 1'b0;
      pulse_count   <= 8'h00;
      node_sync_out <= 1'b0;
    end
    else if (trigger && !delay_run)
    begin
      delay_count <= sync_delay_in;  // RL18
      delay_run   <= 1'b1;
    end
    else if (delay_run)
    begin
      if (delay_count == '0)
      begin
        delay_run     <= 1'b0;
        node_sync_out <= 1'b1;
        pulse_count   <= 8'(SYNC_PULSE_CYCLES);
      end
      else
        delay_count <= delay_count - 1'b1;
    end
    else if (pulse_count > 8'h01)
      pulse_count <= pulse_count - 8'h01;
    else
    begin
      pulse_count   <= 8'h00;
      node_sync_out <= 1'b0;
    end
  end
  // direct mode is combinational so it adds no skew to the alignment budget
  assign filter_sync_out = sync_button_in |  // RL17
    ((sync_mode_in == SYNC_MODE_DIRECT) ? sync_network_in : node_sync_out);  // RL9 RL12

  // -------------------------------------------------------------
  // acquisition and record start marking
  // -------------------------------------------------------------
  acq_t      acq;
  logic [7:0] skip_count;
  logic      first_pending;
  logic      buf_ready;
  logic      fetch_wait;
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      acq           <= ACQ_IDLE;
      skip_count    <= 8'h00;
      first_pending <= 1'b0;
    end
    else
    begin
      unique case (acq)
        ACQ_IDLE:
          if (cmd_take && cmd_code_in == CMD_RUN)
          begin
            acq        <= ACQ_SETTLE;
            skip_count <= 8'h00;
          end
        ACQ_SETTLE:
          if (spi_done && op == OP_FETCH)
          begin
            if (skip_count == 8'(SETTLE - 1))  // RL2
            begin
              acq           <= ACQ_RECORD;
              first_pending <= 1'b1;
            end
            else
              skip_count <= skip_count + 8'h01;
          end
        ACQ_RECORD:
          if (spi_done && op == OP_FETCH)
            first_pending <= 1'b0;
      endcase
      if (cmd_take && cmd_code_in == CMD_STOP)
        acq <= ACQ_IDLE;
    end
  end
  // mark pulses with the first kept sample's fetch
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      record_start_mark <= 1'b0;
    else
      record_start_mark <= (acq == ACQ_RECORD) & first_pending & spi_done & (op == OP_FETCH);  // RL1
  end
  assign filter_record_out = record_button_in | record_start_mark;  // RL17

  // -------------------------------------------------------------
  // serial port sequencing
  // -------------------------------------------------------------
  assign fetch_wait = (acq != ACQ_IDLE) & ~drdy_level & buf_ready;  // RL7
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      op        <= OP_NONE;
      spi_start <= 1'b0;
      spi_tx    <= 32'h0000_0000;
    end
    else
    begin
      spi_start <= 1'b0;
      if (op == OP_NONE && !spi_busy)
      begin
        if (cmd_take && (cmd_code_in == CMD_CFG_WRITE || cmd_code_in == CMD_CFG_READ))
        begin
          op        <= (cmd_code_in == CMD_CFG_WRITE) ? OP_CFG_WRITE : OP_CFG_READ;  // RL6
          spi_tx    <= cmd_data_in;
          spi_start <= 1'b1;
        end
        else if (fetch_wait && !cmd_valid_in)
        begin
          op        <= OP_FETCH;  // RL6
          spi_tx    <= 32'h0000_0000;
          spi_start <= 1'b1;
        end
      end
      else if (spi_done)
        op <= OP_NONE;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cfg_rdata_valid_out <= 1'b0;
      cfg_rdata_out       <= 32'h0000_0000;
    end
    else
    begin
      cfg_rdata_valid_out <= spi_done & (op == OP_CFG_READ);
      if (spi_done && op == OP_CFG_READ)
        cfg_rdata_out <= spi_rx;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      filter_reset_drive_out <= 1'b0;
    else if (cmd_take && cmd_code_in == CMD_FILT_RST)
      filter_reset_drive_out <= ~filter_reset_drive_out;
  end

  spi_master #(.WIDTH(32)) u_spi (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .start_in     (spi_start),
    .tx_in        (spi_tx),
    .busy_out     (spi_busy),
    .done_out     (spi_done),
    .rx_out       (spi_rx),
    .sck_out      (filter_sck_out),
    .mosi_out     (filter_mosi_out),
    .select_n_out (filter_select_n),
    .miso_in      (filter_miso_in)
  );

  // -------------------------------------------------------------
  // collected data buffer (settling samples are dropped)
  // -------------------------------------------------------------
  logic                 keep;
  logic [SBITS:0]       buf_out;
  assign keep = spi_done & (op == OP_FETCH) & (acq == ACQ_RECORD);  // RL2
  sample_buffer #(.WIDTH(SBITS + 1)) u_buf (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (keep),
    .in_ready_out  (buf_ready),
    .in_data_in    ({first_pending, spi_rx[SBITS-1:0]}),
    .out_valid_out (data_valid_out),
    .out_ready_in  (data_ready_in),
    .out_data_out  (buf_out)
  );
  assign data_first_out    = buf_out[SBITS];
  assign data_sample_out   = buf_out[SBITS-1:0];
  assign data_src_addr_out = node_addr_out;  // RL14

  // -------------------------------------------------------------
  // address assignment and chain pass-through
  // -------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      node_addr_out     <= '0;
      chain_pass_enable <= 1'b0;
    end
    else if (addr_assign_in && !chain_pass_enable)
    begin
      node_addr_out     <= addr_value_in;  // RL13
      chain_pass_enable <= 1'b1;  // RL15
    end
  end

  // buffered link: push-pull only while sending, no nack sensing
  assign link_data_drive_en = link_tx_active_in & power_on_reset_n_out;  // RL19 RL16
endmodule // seismic_node_ctrl

// *** node_ctrl_pkg.sv ***
// constants shared by the seismic node controller files
package node_ctrl_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_HZ        = 12000000;
  localparam int POR_TIME_US        = 10;
  localparam int POR_CYCLES         = (CLK_FREQ_HZ / 1000000) * POR_TIME_US;
  localparam int SYNC_PULSE_NS      = 250;
  localparam int SYNC_PULSE_CYCLES  = (SYNC_PULSE_NS * (CLK_FREQ_HZ / 1000000) + 999) / 1000;
  // ---------------------------------------------------------------
  // acquisition
  // ---------------------------------------------------------------
  localparam int SETTLE_SAMPLES     = 100;
  localparam int SAMPLE_BITS        = 24;
  localparam int ADDR_BITS          = 7;
  localparam int DELAY_BITS         = 16;
  localparam int CMD_BITS           = 8;
  localparam int SPI_HALF_DIV       = 3;
  // ---------------------------------------------------------------
  // sync modes
  // ---------------------------------------------------------------
  localparam logic [1:0] SYNC_MODE_DIRECT   = 2'h0;
  localparam logic [1:0] SYNC_MODE_HARDWARE = 2'h1;
  localparam logic [1:0] SYNC_MODE_SOFTWARE = 2'h2;
  // ---------------------------------------------------------------
  // serial port operations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {OP_NONE, OP_CFG_WRITE, OP_CFG_READ, OP_FETCH} spi_op_t;
endpackage

// *** spi_master.sv ***
// serial-port master toward the digital filter
`timescale 1ns/1ps
module spi_master
  import node_ctrl_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int HALF  = SPI_HALF_DIV
)(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // request
  input  wire logic             start_in,
  input  wire logic [WIDTH-1:0] tx_in,
  output logic                  busy_out,
  output logic                  done_out,
  output logic [WIDTH-1:0]      rx_out,
  // pins
  output logic                  sck_out,
  output logic                  mosi_out,
  output logic                  select_n_out,
  input  wire logic             miso_in
);
  import node_ctrl_pkg::*;
  logic [WIDTH-1:0] shift;
  logic [7:0]       bits;
  logic [7:0]       div;
  assign busy_out = ~select_n_out;
  assign mosi_out = shift[WIDTH-1];
  always_ff @(posedge clk_in)
  begin
    done_out <= 1'b0;
    if (!rst_n_in)
    begin
      shift        <= '0;
      bits         <= 8'h00;
      div          <= 8'h00;
      sck_out      <= 1'b0;
      select_n_out <= 1'b1;
      rx_out       <= '0;
    end
    else if (select_n_out)
    begin
      if (start_in)
      begin
        select_n_out <= 1'b0;
        shift        <= tx_in;
        bits         <= 8'(WIDTH);
        div          <= 8'h00;
      end
    end
    else if (div == 8'(HALF - 1))
    begin
      div     <= 8'h00;
      sck_out <= ~sck_out;
      if (sck_out)
      begin
        // shift on falling edge; miso was sampled on the rising one
        shift <= {shift[WIDTH-2:0], shift[0]};
        bits  <= bits - 8'h01;
        if (bits == 8'h01)
        begin
          select_n_out <= 1'b1;
          done_out     <= 1'b1;
          rx_out       <= rx_out;
        end
      end
      else
        rx_out <= {rx_out[WIDTH-2:0], miso_in};
    end
    else
      div <= div + 8'h01;
  end
endmodule // spi_master

// *** sample_buffer.sv ***
// two-entry buffer for collected samples
`timescale 1ns/1ps
module sample_buffer #(
  parameter int WIDTH = 32
)(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  logic [WIDTH-1:0] mem [2];
  logic             rd;
  logic             wr;
  logic [1:0]       count;
  logic             push;
  logic             pop;
  assign in_ready_out  = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_data_out  = mem[rd];
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      rd     <= 1'b0;
      wr     <= 1'b0;
      count  <= 2'h0;
      mem[0] <= '0;
      mem[1] <= '0;
    end
    else
    begin
      if (push)
      begin
        mem[wr] <= in_data_in;
        wr      <= ~wr;
      end
      if (pop)
        rd <= ~rd;
      count <= count + 2'(push) - 2'(pop);
    end
  end
endmodule // sample_buffer

// *** node_ctrl_asserts.sv ***
// concurrent checks on the node controller top ports
`timescale 1ns/1ps
module node_ctrl_asserts
  import node_ctrl_pkg::*;
(
  // clock and reset
  input wire logic                 clk_in,
  input wire logic                 rst_n_in,
  // watched ports
  input wire logic                 power_on_reset_n_out,
  input wire logic [1:0]           sync_mode_in,
  input wire logic                 sync_network_in,
  input wire logic                 sync_button_in,
  input wire logic                 record_button_in,
  input wire logic                 node_sync_out,
  input wire logic                 filter_sync_out,
  input wire logic                 record_start_mark,
  input wire logic                 filter_record_out,
  input wire logic                 data_valid_out,
  input wire logic                 data_ready_in,
  input wire logic [ADDR_BITS-1:0] data_src_addr_out,
  input wire logic [ADDR_BITS-1:0] node_addr_out,
  input wire logic                 addr_assign_in,
  input wire logic                 chain_pass_enable,
  input wire logic                 link_tx_active_in,
  input wire logic                 link_data_drive_en,
  input wire logic                 filter_select_n
);
  import node_ctrl_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // pulse is exactly three cycles wide
  sequence pulse3_s; node_sync_out [*3] ##1 !node_sync_out; endsequence
  sequence frame_s; !filter_select_n [*8]; endsequence
  por_hold_a: assert property ($rose(rst_n_in) |-> !power_on_reset_n_out [*8])
    else $error("reset out early");
  sync_or_a: assert property (sync_mode_in != SYNC_MODE_DIRECT |->
    filter_sync_out == (node_sync_out | sync_button_in)) else $error("filter sync not or");
  direct_pass_a: assert property (sync_mode_in == SYNC_MODE_DIRECT && sync_network_in
    |-> filter_sync_out) else $error("sync not passed");
  mark_or_a: assert property (filter_record_out == (record_start_mark | record_button_in))
    else $error("record output not or");
  mark_pulse_a: assert property (record_start_mark |=> !record_start_mark)
    else $error("mark too long");
  sync_pulse_a: assert property ($rose(node_sync_out) |-> pulse3_s)
    else $error("sync width wrong");
  select_frame_a: assert property ($fell(filter_select_n) |-> frame_s)
    else $error("select dropped");
  chain_open_a: assert property ($rose(chain_pass_enable) |-> $past(addr_assign_in))
    else $error("pass without address");
  drive_en_a: assert property (link_data_drive_en == link_tx_active_in)
    else $error("drive enable wrong");
  src_tag_a: assert property (data_valid_out |-> data_src_addr_out == node_addr_out)
    else $error("source tag wrong");
  data_hold_a: assert property (data_valid_out && !data_ready_in |=> data_valid_out)
    else $error("stalled word lost");
endmodule // node_ctrl_asserts

bind seismic_node_ctrl node_ctrl_asserts i_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .power_on_reset_n_out(power_on_reset_n_out),
  .sync_mode_in(sync_mode_in), .sync_network_in(sync_network_in),
  .sync_button_in(sync_button_in), .record_button_in(record_button_in),
  .node_sync_out(node_sync_out), .filter_sync_out(filter_sync_out),
  .record_start_mark(record_start_mark), .filter_record_out(filter_record_out),
  .data_valid_out(data_valid_out), .data_ready_in(data_ready_in),
  .data_src_addr_out(data_src_addr_out), .node_addr_out(node_addr_out),
  .addr_assign_in(addr_assign_in), .chain_pass_enable(chain_pass_enable),
  .link_tx_active_in(link_tx_active_in), .link_data_drive_en(link_data_drive_en),
  .filter_select_n(filter_select_n));

// *** filter_model.sv ***
// behavioural serial-port filter that raises samples for the controller
`timescale 1ns/1ps
module filter_model #(
  parameter int          GAP      = 40,
  parameter logic [31:0] CFG_WORD = 32'h5a3c_0f96
)(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // conversion enable from the bench
  input  wire logic run_in,
  // serial port
  input  wire logic sck_in,
  input  wire logic select_n_in,
  output logic      miso_out,
  output logic      ready_n_out
);
  logic [31:0] shreg;
  logic [23:0] count;
  logic        sck_d;
  logic        sel_d;
  int          gap;
  always @(posedge clk_in)
  begin
    sck_d <= sck_in;
    sel_d <= select_n_in;
    if (!rst_n_in)
    begin
      count       <= 24'h000001;
      ready_n_out <= 1'b1;
      gap         <= GAP;
      miso_out    <= 1'b0;
    end
    else if (sel_d && !select_n_in)
    begin
      // pending sample, else config word
      shreg    <= ready_n_out ? CFG_WORD : {8'h00, count};
      miso_out <= ready_n_out ? CFG_WORD[31] : 1'b0;
      if (!ready_n_out)
      begin
        count       <= count + 24'h000001;
        ready_n_out <= 1'b1;
        gap         <= GAP;
      end
    end
    else if (!select_n_in)
    begin
      if (sck_d && !sck_in)
      begin
        miso_out <= shreg[30];
        shreg    <= shreg << 1;
      end
    end
    else
    begin
      // released line must not look like held data
      miso_out <= ~miso_out;
      if (run_in && ready_n_out)
      begin
        if (gap == 0) ready_n_out <= 1'b0;
        else gap <= gap - 1;
      end
    end
  end
endmodule // filter_model

// *** tb_seismic_node_ctrl.sv ***
// self-checking bench for the node controller
`timescale 1ns/1ps
module tb_seismic_node_ctrl;
  import node_ctrl_pkg::*;
  localparam int          SETTLE = 3;
  localparam logic [31:0] CFG    = 32'h5a3c_0f96;
  logic clk_in = 0, rst_n_in = 0, sync_network_in = 0, sync_button_in = 0;
  logic record_button_in = 0, cmd_valid_in = 0, data_ready_in = 0, addr_assign_in = 0;
  logic link_tx_active_in = 0, run = 0;
  logic [1:0] sync_mode_in = 0;
  logic [15:0] sync_delay_in = 0;
  logic [6:0] cmd_addr_in = 0, addr_value_in = 0, data_src_addr_out, node_addr_out;
  logic [7:0] cmd_code_in = 0;
  logic [31:0] cmd_data_in = 0, cfg_rdata_out;
  logic [23:0] data_sample_out;
  logic por_n, rst_drv, node_sync_out, filter_sync_out, record_start_mark, filt_rec;
  logic cmd_ready_out, cfg_valid, data_valid_out, data_first_out, chain_pass_enable;
  logic link_data_drive_en, sck, mosi, filter_select_n, miso, sample_ready_n;
  int err_count = 0, total_checks = 0, marks = 0, n, k;
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) if (record_start_mark === 1'b1) marks <= marks + 1;
  seismic_node_ctrl #(.SETTLE(SETTLE)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .power_on_reset_n_out(por_n), .filter_reset_drive_out(rst_drv),
    .sync_mode_in(sync_mode_in), .sync_delay_in(sync_delay_in),
    .sync_network_in(sync_network_in), .sync_button_in(sync_button_in),
    .record_button_in(record_button_in), .node_sync_out(node_sync_out),
    .filter_sync_out(filter_sync_out), .record_start_mark(record_start_mark),
    .filter_record_out(filt_rec), .cmd_valid_in(cmd_valid_in),
    .cmd_ready_out(cmd_ready_out), .cmd_addr_in(cmd_addr_in), .cmd_code_in(cmd_code_in),
    .cmd_data_in(cmd_data_in), .cfg_rdata_valid_out(cfg_valid),
    .cfg_rdata_out(cfg_rdata_out), .data_valid_out(data_valid_out),
    .data_ready_in(data_ready_in), .data_src_addr_out(data_src_addr_out),
    .data_sample_out(data_sample_out), .data_first_out(data_first_out),
    .addr_assign_in(addr_assign_in), .addr_value_in(addr_value_in),
    .node_addr_out(node_addr_out), .chain_pass_enable(chain_pass_enable),
    .link_tx_active_in(link_tx_active_in), .link_data_drive_en(link_data_drive_en),
    .filter_sck_out(sck), .filter_mosi_out(mosi), .filter_select_n(filter_select_n),
    .filter_miso_in(miso), .sample_ready_n(sample_ready_n));
  filter_model #(.CFG_WORD(CFG)) i_filter (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .run_in(run), .sck_in(sck), .select_n_in(filter_select_n), .miso_out(miso),
    .ready_n_out(sample_ready_n));
  // ----------
  // tasks
  // ----------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task test_done;
    if (err_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task bail;
    err_count++;
    test_done();
  endtask
  // request held until the edge that samples ready high
  task send_cmd(input logic [6:0] a, input logic [7:0] c, input logic [31:0] d);
    int i;
    @(posedge clk_in);
    cmd_valid_in <= 1'b1;
    cmd_addr_in  <= a;
    cmd_code_in  <= c;
    cmd_data_in  <= d;
    for (i = 0; i < 400; i++)
    begin
      @(posedge clk_in);
      if (cmd_ready_out === 1'b1) break;
    end
    if (i == 400) bail();
    cmd_valid_in <= 1'b0;
  endtask
  task waitc(input int w, input int lim, output int c);
    for (c = 1; c <= lim; c++)
    begin
      @(posedge clk_in);
      #1;
      if ((w == 0 && node_sync_out === 1'b1) || (w == 1 && cfg_valid === 1'b1)) return;
    end
  endtask
  // ----------
  // main sequence
  // ----------
  initial
  begin
    repeat (8) @(posedge clk_in);
    #1 check(por_n, 0);
    check(filter_select_n, 1);
    @(posedge clk_in) rst_n_in <= 1'b1;
    repeat (100) @(posedge clk_in);
    #1 check(por_n, 0);
    repeat (30) @(posedge clk_in);
    #1 check(por_n, 1);
    @(posedge clk_in) {addr_assign_in, addr_value_in} <= {1'b1, 7'h15};
    @(posedge clk_in) {addr_assign_in, addr_value_in} <= {1'b1, 7'h22};
    @(posedge clk_in) addr_assign_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 check(node_addr_out, 7'h15);
    check(chain_pass_enable, 1);
    @(posedge clk_in) link_tx_active_in <= 1'b1;
    #1 check(link_data_drive_en, 1);
    @(posedge clk_in) link_tx_active_in <= 1'b0;
    #1 check(link_data_drive_en, 0);
    send_cmd(7'h15, 8'h06, 0);
    repeat (3) @(posedge clk_in);
    #1 check(rst_drv, 1);
    @(posedge clk_in) sync_mode_in <= SYNC_MODE_SOFTWARE;
    send_cmd(7'h16, 8'h03, 0);
    waitc(0, 40, n);
    check(n, 41);
    for (k = 0; k < 2; k++)
    begin
      @(posedge clk_in) sync_delay_in <= 16'(5 * k);
      send_cmd(7'h15, 8'h03, 0);
      waitc(0, 40, n);
      check(n, k ? 6 : 1);
      repeat (6) @(posedge clk_in);
    end
    @(posedge clk_in) {sync_button_in, record_button_in} <= 2'b11;
    #1 check({filter_sync_out, filt_rec}, 2'b11);
    @(posedge clk_in) {sync_button_in, record_button_in} <= 2'b00;
    {sync_mode_in, sync_delay_in} <= {SYNC_MODE_HARDWARE, 16'h0004};
    @(posedge clk_in) sync_network_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sync_network_in <= 1'b0;
    waitc(0, 40, n);
    check(n >= 4 && n <= 12, 1);
    repeat (6) @(posedge clk_in);
    sync_mode_in <= SYNC_MODE_DIRECT;
    @(posedge clk_in) sync_network_in <= 1'b1;
    #1 check(filter_sync_out, 1);
    @(posedge clk_in) sync_network_in <= 1'b0;
    send_cmd(7'h15, 8'h02, 32'h0000_0010);
    waitc(1, 400, n);
    if (n > 400) bail();
    check(cfg_rdata_out, CFG);
    @(posedge clk_in) run <= 1'b1;
    send_cmd(7'h15, 8'h04, 0);
    repeat (1500) @(posedge clk_in);
    data_ready_in <= 1'b1;
    k = 0;
    for (n = 0; n < 4000 && k < 4; n++)
    begin
      @(posedge clk_in);
      if (data_valid_out === 1'b1)
      begin
        check(data_sample_out, SETTLE + 1 + k);
        check(data_first_out, k == 0);
        check(data_src_addr_out, 7'h15);
        k++;
      end
    end
    if (k < 4) bail();
    check(marks, 1);
    send_cmd(7'h15, 8'h05, 0);
    test_done();
  end
endmodule // tb_seismic_node_ctrl
